// [rtl/sfr_decoder.sv]
// Special-function command decoder and control register for a 32-channel DAC.
// Assumes the interface delivers one decoded command word per cmd_valid pulse.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Both select bits zero choose functions
// - Code 01001 powers amplifiers and reference
// - Power-up exit takes 8 us; a thermal shutdown clears the cycle after the command once cooled
// - Power-down is hardware OR software OR thermal
// - Software power-down rejects register writes
// - Code 01111 resets registers to defaults
// - Soft reset clears DAC registers
// - Soft reset completes within 135 us
// - Code 01100 writes or reads control
// - Bit 13 selects power-down output load
// - Bit 12 selects reference level
// - Bit 11 enables amplifier boost
// - Bit 10 enables internal reference
// - Bit 9 enables monitor, else float
// - Bit 8 thermal shutdown above threshold
// - Power-up recovers only when cooled
// - Bits 7,6,1,0 ignored
// - Bits 5-2 enable group toggle
// - Group bits map eight channels each
// - Code 01010 loads six-bit monitor address
// - Address routes channels and external inputs
// - Address 63 floats monitor output
module sfr_decoder
	import sfr_pkg::*;
#(
	parameter logic REF_LEVEL_DEFAULT = 1'b1  // Supply variant reference default
) (
	input wire logic clock_in,                 // Core clock
	input wire logic resetn_in,                // Asynchronous reset, active low
	input wire logic cmd_valid_in,             // One-cycle command strobe
	input wire logic reg_select_hi_in,         // Register select high
	input wire logic reg_select_lo_in,         // Register select low
	input wire logic read_in,                  // Read when high
	input wire logic [4:0] function_address_in, // Function address
	input wire logic [13:0] command_payload_in, // Command payload
	input wire logic hw_power_down_in,         // Hardware power-down pin
	input wire logic over_temp_in,             // Die above 130 C
	output logic [13:0] readback_data_out,     // Control readback
	output logic readback_valid_out,           // One-cycle readback strobe
	output logic power_down_out,               // Effective power-down
	output logic pd_output_state_out,          // High-Z in power-down
	output logic ref_level_select_out,         // 2.5 V when high
	output logic amp_boost_out,                // Boost on
	output logic internal_ref_enable_out,      // Internal reference on
	output logic [3:0] toggle_group_enable_out, // Group toggle enables
	output logic [31:0] toggle_channel_enable_out, // Per-channel toggle
	output logic dac_clear_out,                // Clear DAC registers pulse
	output logic coef_reset_out,               // Restore m and c pulse
	output logic reset_busy_out,               // Soft reset in progress
	output logic [31:0] monitor_channel_sel_out, // Channel route
	output logic [3:0] monitor_ext_sel_out,    // External input route
	output logic monitor_output_oe_out         // Monitor output driven
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [13:0] device_control_reg;       // Control register
	logic [5:0] monitor_source_select_reg; // Monitor address
	logic sw_pd_reg;                       // Software power-down
	logic thermal_pd_reg;                  // Thermal shutdown latch
	logic waking_reg;                      // Power-up exit in progress
	seq_state_t state_reg;                 // Sequencer state
	logic [TIMER_W-1:0] timer_reg;         // Sequencer counter
	logic sfr_cmd;                         // Special-function command taken
	logic wr_allowed;                      // Write not blocked
	logic [13:0] ctrl_reset_value;         // Default control word
	logic [TIMER_W-1:0] busy_len_reg; // Check helper: soft reset length so far
	logic [TIMER_W-1:0] wake_len_reg; // Check helper: power-up exit length so far

	// True when the function address equals this code; select bits not checked
	function automatic logic is_func(input logic [4:0] f, input logic [4:0] code);
		is_func = (f == code);
	endfunction : is_func

	assign ctrl_reset_value = CTRL_RESET_BASE | (14'(REF_LEVEL_DEFAULT) << BIT_REF_LEVEL);
	// Commands ignored while soft reset runs
	assign sfr_cmd = cmd_valid_in && !reg_select_hi_in && !reg_select_lo_in
		&& (state_reg != ST_RESET);
	assign wr_allowed = !sw_pd_reg;

	// ****************************************
	// Sequencer
	// ****************************************
	// Times power-up exit and soft reset
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (sfr_cmd && !read_in && is_func(function_address_in, FN_SOFT_RESET)) begin
						state_reg <= ST_RESET;
						timer_reg <= TIMER_W'(SOFT_RESET_CYC - 1);
					end else if (sfr_cmd && !read_in
						&& is_func(function_address_in, FN_PWR_UP)) begin
						state_reg <= ST_WAKE;
						timer_reg <= TIMER_W'(PWR_UP_CYC - 1);
					end
				end
				ST_WAKE: begin
					// Soft reset overrides a pending wake
					if (sfr_cmd && !read_in && is_func(function_address_in, FN_SOFT_RESET)) begin
						state_reg <= ST_RESET;
						timer_reg <= TIMER_W'(SOFT_RESET_CYC - 1);
					end else if (sfr_cmd && !read_in
						&& is_func(function_address_in, FN_PWR_UP)) begin
						// A repeated power-up restarts the full exit time
						timer_reg <= TIMER_W'(PWR_UP_CYC - 1);
					end else if (timer_reg == '0) begin
						state_reg <= ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				ST_RESET: begin
					if (timer_reg == '0) begin
						state_reg <= ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Power-down state
	// ****************************************
	// Software power-down and wake flag
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sw_pd_reg <= 1'b0;
			waking_reg <= 1'b0;
		end else begin
			if (state_reg == ST_RESET) begin
				sw_pd_reg <= 1'b0;
				waking_reg <= 1'b0;
			end else if (sfr_cmd && !read_in && is_func(function_address_in, FN_PWR_DOWN)) begin
				sw_pd_reg <= 1'b1;
				waking_reg <= 1'b0;
			end else if (sfr_cmd && !read_in && is_func(function_address_in, FN_PWR_UP)) begin
				waking_reg <= 1'b1;
			end else if (state_reg == ST_WAKE && timer_reg == '0 && waking_reg) begin
				// A power-down taken during the wake keeps the device down
				sw_pd_reg <= 1'b0;
				waking_reg <= 1'b0;
			end
		end
	end

	// Thermal shutdown latch; set wins over power-up
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			thermal_pd_reg <= 1'b0;
		end else begin
			if (device_control_reg[BIT_THERM_EN] && over_temp_in) begin
				thermal_pd_reg <= 1'b1;
			end else if ((state_reg == ST_RESET)
				|| (sfr_cmd && !read_in && is_func(function_address_in, FN_PWR_UP))) begin
				thermal_pd_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Control register write and soft reset
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			device_control_reg <= CTRL_RESET_BASE | (14'(REF_LEVEL_DEFAULT) << BIT_REF_LEVEL);
		end else begin
			if (state_reg == ST_RESET) begin
				device_control_reg <= ctrl_reset_value;
			end else if (sfr_cmd && !read_in && wr_allowed
				&& is_func(function_address_in, FN_CTRL)) begin
				device_control_reg <= command_payload_in & CTRL_MASK;
			end
		end
	end

	// Monitor address write
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			monitor_source_select_reg <= MON_ADDR_OFF;
		end else begin
			if (state_reg == ST_RESET) begin
				monitor_source_select_reg <= MON_ADDR_OFF;
			end else if (sfr_cmd && !read_in && wr_allowed
				&& is_func(function_address_in, FN_MON_SEL)) begin
				monitor_source_select_reg <= command_payload_in[13:MON_LSB];
			end
		end
	end

	// Readback path
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			readback_data_out <= '0;
			readback_valid_out <= 1'b0;
		end else begin
			readback_valid_out <= 1'b0;
			if (sfr_cmd && read_in && is_func(function_address_in, FN_CTRL)) begin
				readback_data_out <= device_control_reg & CTRL_MASK;
				readback_valid_out <= 1'b1;
			end
		end
	end

	// Reset pulses to datapath
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dac_clear_out <= 1'b0;
			coef_reset_out <= 1'b0;
		end else begin
			dac_clear_out <= sfr_cmd && !read_in && is_func(function_address_in, FN_SOFT_RESET);
			coef_reset_out <= sfr_cmd && !read_in && is_func(function_address_in, FN_SOFT_RESET);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign power_down_out = hw_power_down_in | sw_pd_reg | thermal_pd_reg;
	assign pd_output_state_out = device_control_reg[BIT_PD_STATE];
	assign ref_level_select_out = device_control_reg[BIT_REF_LEVEL];
	assign amp_boost_out = device_control_reg[BIT_BOOST];
	assign internal_ref_enable_out = device_control_reg[BIT_INT_REF];
	assign toggle_group_enable_out = device_control_reg[TOGGLE_LSB +: 4];
	assign reset_busy_out = (state_reg == ST_RESET);

	// Each group bit covers eight channels
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			toggle_channel_enable_out[g*8 +: 8] = {8{toggle_group_enable_out[g]}};
		end
	end

	// Monitor route decoder
	monitor_mux u_monitor_mux (
		.addr_in(monitor_source_select_reg),
		.enable_in(device_control_reg[BIT_MON_EN]),
		.channel_sel_out(monitor_channel_sel_out),
		.ext_sel_out(monitor_ext_sel_out),
		.drive_out(monitor_output_oe_out)
	);

	// ****************************************
	// Check helpers
	// ****************************************
	// Counts cycles the soft reset has been running
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_len_reg <= '0;
		end else begin
			if (reset_busy_out) begin
				busy_len_reg <= busy_len_reg + 1'b1;
			end else begin
				busy_len_reg <= '0;
			end
		end
	end

	// Counts power-up exit cycles since the last power-up command was taken
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wake_len_reg <= '0;
		end else begin
			if (sfr_cmd && !read_in && is_func(function_address_in, FN_PWR_UP)) begin
				wake_len_reg <= '0;
			end else if (waking_reg) begin
				wake_len_reg <= wake_len_reg + 1'b1;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_soft_reset_time: assert property (@(posedge clock_in) disable iff (!resetn_in)
		reset_busy_out |-> busy_len_reg < TIMER_W'(SOFT_RESET_CYC))
		else $error("soft reset runs too long");
	a_pd_or: assert property (@(posedge clock_in) disable iff (!resetn_in)
		hw_power_down_in |-> power_down_out)
		else $error("hardware power-down not honoured");
	a_wake_delay: assert property (@(posedge clock_in) disable iff (!resetn_in)
		($fell(sw_pd_reg) && !reset_busy_out) |-> wake_len_reg == TIMER_W'(PWR_UP_CYC))
		else $error("power-up exit not 8 us");
	a_pd_blocks_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sw_pd_reg && state_reg != ST_RESET) |=> $stable(device_control_reg))
		else $error("write during power-down");
	a_ctrl_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sfr_cmd && !read_in && !sw_pd_reg && function_address_in == FN_CTRL)
		|=> device_control_reg == ($past(command_payload_in) & 14'h3f3c))
		else $error("control write lost");
	a_readback_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
		readback_valid_out |-> (readback_data_out & 14'h00c3) == 14'h0000)
		else $error("readback unused bits set");
	a_thermal_trip: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(device_control_reg[BIT_THERM_EN] && over_temp_in) |=> power_down_out)
		else $error("thermal shutdown missed");
	a_mon_float: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(monitor_source_select_reg == 6'h3f || !device_control_reg[BIT_MON_EN])
		|-> !monitor_output_oe_out)
		else $error("monitor driven when off");
	a_reset_default: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$fell(reset_busy_out) |-> device_control_reg == ctrl_reset_value)
		else $error("soft reset default wrong");
	a_clear_pulse: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sfr_cmd && !read_in && function_address_in == FN_SOFT_RESET)
		|=> (dac_clear_out && coef_reset_out))
		else $error("soft reset pulses missing");
	a_readback_value: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sfr_cmd && read_in && function_address_in == FN_CTRL)
		|=> (readback_valid_out && readback_data_out == ($past(device_control_reg) & 14'h3f3c)))
		else $error("control readback wrong");
	a_mon_write: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sfr_cmd && !read_in && !sw_pd_reg && function_address_in == FN_MON_SEL)
		|=> {monitor_source_select_reg, 8'h00} == ($past(command_payload_in) & 14'h3f00))
		else $error("monitor address write lost");
	a_hot_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(device_control_reg[BIT_THERM_EN] && over_temp_in) |=> thermal_pd_reg)
		else $error("power-up cleared shutdown while hot");
	a_mon_blocked: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sw_pd_reg && state_reg != ST_RESET) |=> $stable(monitor_source_select_reg))
		else $error("monitor write during power-down");
	a_cmd_ignored: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(cmd_valid_in && (reg_select_hi_in || reg_select_lo_in) && state_reg != ST_RESET)
		|=> $stable(device_control_reg))
		else $error("non-special command changed control");
endmodule : sfr_decoder
`default_nettype wire

// [rtl/sfr_pkg.sv]
// Constants for the special-function command decoder of a 32-channel DAC.
// Assumes a 10 MHz core clock and a pre-framed command word from the interface.
`default_nettype none
package sfr_pkg;
	// ****************************************
	// Command fields
	// ****************************************
	localparam int unsigned FUNC_W = 5;
	localparam int unsigned PAYLOAD_W = 14;
	localparam logic [4:0] FN_NOP = 5'h00;
	localparam logic [4:0] FN_PWR_DOWN = 5'h08;
	localparam logic [4:0] FN_PWR_UP = 5'h09;
	localparam logic [4:0] FN_MON_SEL = 5'h0a;
	localparam logic [4:0] FN_CTRL = 5'h0c;
	localparam logic [4:0] FN_SOFT_RESET = 5'h0f;
	// ****************************************
	// Control register layout
	// ****************************************
	localparam int unsigned BIT_PD_STATE = 13;
	localparam int unsigned BIT_REF_LEVEL = 12;
	localparam int unsigned BIT_BOOST = 11;
	localparam int unsigned BIT_INT_REF = 10;
	localparam int unsigned BIT_MON_EN = 9;
	localparam int unsigned BIT_THERM_EN = 8;
	localparam int unsigned TOGGLE_LSB = 2;
	localparam logic [13:0] CTRL_MASK = 14'h3f3c;
	localparam logic [13:0] CTRL_RESET_BASE = 14'h2000;
	// ****************************************
	// Monitor select
	// ****************************************
	localparam int unsigned MON_LSB = 8;
	localparam logic [5:0] MON_ADDR_OFF = 6'h3f;
	localparam logic [5:0] MON_EXT_BASE = 6'h20;
	localparam logic [5:0] MON_EXT_LAST = 6'h23;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_MHZ = 10;
	localparam int unsigned PWR_UP_US = 8;
	localparam int unsigned SOFT_RESET_US = 135;
	localparam int unsigned PWR_UP_CYC = PWR_UP_US * CLK_MHZ;
	localparam int unsigned SOFT_RESET_CYC = SOFT_RESET_US * CLK_MHZ;
	localparam int unsigned TIMER_W = 11;
	typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_RESET} seq_state_t;
endpackage : sfr_pkg
`default_nettype wire

// [rtl/monitor_mux.sv]
// Monitor source decoder: maps the six-bit monitor address to a one-hot route.
// Assumes the analogue switch matrix outside acts on the select bits.
`timescale 1ns/1ps
`default_nettype none
module monitor_mux
	import sfr_pkg::*;
(
	input wire logic [5:0] addr_in,       // Stored monitor address
	input wire logic enable_in,           // Monitor enable control bit
	output logic [31:0] channel_sel_out,  // One-hot channel route
	output logic [3:0] ext_sel_out,       // One-hot external input route
	output logic drive_out                // Monitor output driven
);
	// ****************************************
	// Address decode
	// ****************************************
	always_comb begin
		channel_sel_out = '0;
		ext_sel_out = '0;
		// Channels 0 to 31
		if (enable_in && !addr_in[5]) begin
			channel_sel_out[addr_in[4:0]] = 1'b1;
		end
		// External inputs 1 to 4
		if (enable_in && addr_in >= MON_EXT_BASE && addr_in <= MON_EXT_LAST) begin
			ext_sel_out[addr_in[1:0]] = 1'b1;
		end
	end
	// Undefined codes still drive; disabled or code 63 floats
	assign drive_out = enable_in && (addr_in != MON_ADDR_OFF);
endmodule : monitor_mux
`default_nettype wire

// [dv/host_model.sv]
// Host model: issues one command word per strobe, special-function or any other register select.
// Assumes the decoder samples on the rising edge; drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clock_in,                    // Core clock
	output logic cmd_valid_out,                   // Command strobe
	output logic reg_select_hi_out,               // Register select high
	output logic reg_select_lo_out,               // Register select low
	output logic read_out,                        // Read when high
	output logic [4:0] function_address_out,      // Function code
	output logic [13:0] command_payload_out       // Payload
);
	// ****************************************
	// Idle bus
	// ****************************************
	initial begin
		cmd_valid_out = 1'b0;
		reg_select_hi_out = 1'b0;
		reg_select_lo_out = 1'b0;
		read_out = 1'b0;
		function_address_out = 5'h00;
		command_payload_out = 14'h0000;
	end
	// ****************************************
	// One command, held across its taking edge
	// ****************************************
	task automatic send(input logic [4:0] fn, input logic rd, input logic [13:0] data);
		send_sel(2'b00, fn, rd, data);
	endtask : send
	// Any register select, for words that are not special functions
	task automatic send_sel(input logic [1:0] sel, input logic [4:0] fn, input logic rd,
		input logic [13:0] data);
		@(negedge clock_in);
		reg_select_hi_out = sel[1];
		reg_select_lo_out = sel[0];
		read_out = rd;
		function_address_out = fn;
		command_payload_out = data;
		cmd_valid_out = 1'b1;
		@(negedge clock_in);
		cmd_valid_out = 1'b0;
		// Stale payload inverted so nothing relies on it
		command_payload_out = ~data;
		function_address_out = ~fn;
	endtask : send_sel
endmodule : host_model
`default_nettype wire

// [dv/dac_sfr_control_decoder_tb_top.sv]
// Testbench for the special-function decoder: one task per scenario.
// Assumes sfr_pkg, sfr_decoder and host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dac_sfr_control_decoder_tb_top;
	import sfr_pkg::*;
	logic clock_in, resetn_in, hw_pd, hot, cv, rs_hi, rs_lo, rd;
	logic [4:0] fn;
	logic [13:0] pl, rb_data;
	logic rb_valid, pd, pd_st, ref_lvl, boost, int_ref, clr, coef, busy, mon_oe;
	logic [3:0] tg, ext_sel;
	logic [31:0] tch, ch_sel;
	int bad_count = 0;
	int samples_checked = 0;
	// ****************************************
	// Clock and instances
	// ****************************************
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	host_model u_host_model (.clock_in(clock_in), .cmd_valid_out(cv),
		.reg_select_hi_out(rs_hi), .reg_select_lo_out(rs_lo), .read_out(rd),
		.function_address_out(fn), .command_payload_out(pl));
	sfr_decoder u_sfr_decoder (.clock_in(clock_in), .resetn_in(resetn_in),
		.cmd_valid_in(cv), .reg_select_hi_in(rs_hi), .reg_select_lo_in(rs_lo),
		.read_in(rd), .function_address_in(fn), .command_payload_in(pl),
		.hw_power_down_in(hw_pd), .over_temp_in(hot), .readback_data_out(rb_data),
		.readback_valid_out(rb_valid), .power_down_out(pd), .pd_output_state_out(pd_st),
		.ref_level_select_out(ref_lvl), .amp_boost_out(boost),
		.internal_ref_enable_out(int_ref), .toggle_group_enable_out(tg),
		.toggle_channel_enable_out(tch), .dac_clear_out(clr), .coef_reset_out(coef),
		.reset_busy_out(busy), .monitor_channel_sel_out(ch_sel),
		.monitor_ext_sel_out(ext_sel), .monitor_output_oe_out(mon_oe));
	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [4:0] f, input logic [13:0] d);
		u_host_model.send(f, 1'b0, d);
		@(negedge clock_in);
	endtask : wr
	task automatic read_check(input logic [13:0] exp);
		int i;
		u_host_model.send(FN_CTRL, 1'b1, 14'h0000);
		for (i = 0; i < 4 && rb_valid !== 1'b1; i++) @(negedge clock_in);
		check("readback_valid", 32'h1, {31'h0, rb_valid});
		check("readback_data", {18'h0, exp}, {18'h0, rb_data});
	endtask : read_check
	// Polls power-down for a target level within a bound
	task automatic wait_pd(input logic lvl, input int bound);
		int i;
		for (i = 0; i < bound && pd !== lvl; i++) @(negedge clock_in);
		check("power_down", {31'h0, lvl}, {31'h0, pd});
	endtask : wait_pd
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_defaults();
		check("ctrl_bits", 32'hc, {28'h0, pd_st, ref_lvl, boost, int_ref});
		check("monitor_oe", 32'h0, {31'h0, mon_oe});
		read_check(14'h3000);
	endtask : t_defaults
	task automatic t_control();
		wr(FN_CTRL, 14'h3fff);
		check("ctrl_bits", 32'hf, {28'h0, pd_st, ref_lvl, boost, int_ref});
		check("toggle_groups", 32'hf, {28'h0, tg});
		read_check(14'h3f3c);
		wr(FN_CTRL, 14'h0224);
		check("ctrl_bits", 32'h0, {28'h0, pd_st, ref_lvl, boost, int_ref});
		check("toggle_chan", 32'hff0000ff, tch);
		read_check(14'h0224);
		u_host_model.send_sel(2'b11, FN_CTRL, 1'b0, 14'h3fff);
		read_check(14'h0224);
		u_host_model.send_sel(2'b01, FN_SOFT_RESET, 1'b0, 14'h0000);
		check("busy", 32'h0, {31'h0, busy});
	endtask : t_control
	task automatic t_monitor();
		wr(FN_MON_SEL, 14'h05ff);
		check("mon_chan", 32'h20, ch_sel);
		check("monitor_oe", 32'h1, {31'h0, mon_oe});
		wr(FN_MON_SEL, 14'h21aa);
		check("mon_ext", 32'h2, {28'h0, ext_sel});
		wr(FN_MON_SEL, 14'h3f00);
		check("monitor_oe", 32'h0, {31'h0, mon_oe});
		wr(FN_MON_SEL, 14'h0300);
		wr(FN_CTRL, 14'h0000);
		check("monitor_oe", 32'h0, {31'h0, mon_oe});
	endtask : t_monitor
	task automatic t_power();
		hw_pd = 1'b1;
		wait_pd(1'b1, 2);
		hw_pd = 1'b0;
		wait_pd(1'b0, 2);
		wr(FN_PWR_DOWN, 14'h0000);
		check("power_down", 32'h1, {31'h0, pd});
		wr(FN_CTRL, 14'h0800);
		wr(FN_MON_SEL, 14'h0500);
		read_check(14'h0000);
		u_host_model.send(FN_PWR_UP, 1'b0, 14'h3fff);
		repeat (79) @(negedge clock_in);
		check("power_down", 32'h1, {31'h0, pd});
		wait_pd(1'b0, 1);
	endtask : t_power
	task automatic t_thermal();
		wr(FN_CTRL, 14'h0300);
		check("mon_chan", 32'h8, ch_sel);
		hot = 1'b1;
		wait_pd(1'b1, 3);
		u_host_model.send(FN_PWR_UP, 1'b0, 14'h0000);
		repeat (90) @(negedge clock_in);
		check("power_down", 32'h1, {31'h0, pd});
		hot = 1'b0;
		u_host_model.send(FN_PWR_UP, 1'b0, 14'h0000);
		wait_pd(1'b0, 90);
	endtask : t_thermal
	task automatic t_soft_reset();
		int n;
		logic saw_clr, saw_coef;
		saw_clr = 1'b0;
		saw_coef = 1'b0;
		wr(FN_CTRL, 14'h3f3c);
		u_host_model.send(FN_SOFT_RESET, 1'b0, 14'h1234);
		for (n = 0; n < 1400 && (busy === 1'b1 || n < 2); n++) begin
			saw_clr |= (clr === 1'b1);
			saw_coef |= (coef === 1'b1);
			@(negedge clock_in);
		end
		check("busy_ends", 32'h1, {31'h0, n <= SOFT_RESET_CYC});
		check("dac_clear", 32'h1, {31'h0, saw_clr});
		check("coef_reset", 32'h1, {31'h0, saw_coef});
		read_check(14'h3000);
	endtask : t_soft_reset
	// ****************************************
	// Verdict
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	initial begin
		resetn_in = 1'b0;
		hw_pd = 1'b0;
		hot = 1'b0;
		repeat (10) @(negedge clock_in);
		resetn_in = 1'b1;
		t_defaults();
		t_control();
		t_monitor();
		t_power();
		t_thermal();
		t_soft_reset();
		wrap_up();
	end
endmodule : dac_sfr_control_decoder_tb_top
`default_nettype wire
